/* File: pgd_datapath.sv */
// planar graphics datapath: index/data registers, write lanes, read and compare
`default_nettype none
module pgd_datapath (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic cpu_a0,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic [31:0] mem_rdata,
  output logic [31:0] mem_wdata,
  output logic [3:0] mem_plane_we,
  output logic [1:0] shift_format
);
  // register file state
  logic [3:0] idx_ff, nxt_idx_ff;
  logic [3:0] fill_ff, nxt_fill_ff;
  logic [3:0] fill_en_ff, nxt_fill_en_ff;
  logic [3:0] cmp_ff, nxt_cmp_ff;
  logic [2:0] rot_ff, nxt_rot_ff;
  pgd_pkg::pgd_op_e op_ff, nxt_op_ff;
  logic [1:0] rdpl_ff, nxt_rdpl_ff;
  pgd_pkg::pgd_wmode_e wmode_ff, nxt_wmode_ff;
  logic rdcmp_ff, nxt_rdcmp_ff;
  logic oe_ff, nxt_oe_ff;
  logic shf_oe_ff, nxt_shf_oe_ff;
  logic shf256_ff, nxt_shf256_ff;
  logic [3:0] ignore_ff, nxt_ignore_ff;
  logic [7:0] mask_ff, nxt_mask_ff;
  logic [7:0] io_rdata_ff, nxt_io_rdata_ff;
  logic [7:0] reg_view;
  // datapath state
  logic [31:0] latch_ff, nxt_latch_ff;
  logic [7:0] cpu_rdata_ff, nxt_cpu_rdata_ff;
  logic [31:0] mem_wdata_ff, nxt_mem_wdata_ff;
  logic [3:0] we_ff, nxt_we_ff;
  logic [1:0] shift_ff, nxt_shift_ff;
  logic [15:0] rot_wide;
  logic [31:0] lane_out;
  logic [1:0] rd_plane;

  pgd_lane_if lif ();

  assign rot_wide = {cpu_wdata, cpu_wdata} >> rot_ff; // RL7
  assign lif.rot_data = rot_wide[7:0];
  assign lif.cpu_data = cpu_wdata;
  assign lif.bit_mask = mask_ff;
  assign lif.fill = fill_ff;
  assign lif.fill_en = fill_en_ff;
  assign lif.wmode = wmode_ff;
  assign lif.op = op_ff;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      pgd_plane_lane #(.PLANE(g)) u_lane (
        .lif(lif),
        .latch(latch_ff[8*g +: 8]),
        .result(lane_out[8*g +: 8])
      );
    end
  endgenerate

  always_comb begin
    case (idx_ff)
      pgd_pkg::PGD_IDX_FILL: reg_view = {pgd_pkg::PGD_NIBBLE_ZERO, fill_ff};
      pgd_pkg::PGD_IDX_FILL_EN: reg_view = {pgd_pkg::PGD_NIBBLE_ZERO, fill_en_ff};
      pgd_pkg::PGD_IDX_CMP: reg_view = {pgd_pkg::PGD_NIBBLE_ZERO, cmp_ff};
      pgd_pkg::PGD_IDX_OPROT: reg_view = {3'h0, op_ff, rot_ff};
      pgd_pkg::PGD_IDX_RDPL: reg_view = {6'h00, rdpl_ff};
      pgd_pkg::PGD_IDX_MODE: reg_view = {1'b0, shf256_ff, shf_oe_ff, oe_ff, rdcmp_ff, 1'b0, wmode_ff};
      pgd_pkg::PGD_IDX_IGNORE: reg_view = {pgd_pkg::PGD_NIBBLE_ZERO, ignore_ff};
      pgd_pkg::PGD_IDX_MASK: reg_view = mask_ff;
      default: reg_view = pgd_pkg::PGD_BYTE_ZERO;
    endcase
  end

  always_comb begin
    nxt_idx_ff = idx_ff;
    nxt_fill_ff = fill_ff;
    nxt_fill_en_ff = fill_en_ff;
    nxt_cmp_ff = cmp_ff;
    nxt_rot_ff = rot_ff;
    nxt_op_ff = op_ff;
    nxt_rdpl_ff = rdpl_ff;
    nxt_wmode_ff = wmode_ff;
    nxt_rdcmp_ff = rdcmp_ff;
    nxt_oe_ff = oe_ff;
    nxt_shf_oe_ff = shf_oe_ff;
    nxt_shf256_ff = shf256_ff;
    nxt_ignore_ff = ignore_ff;
    nxt_mask_ff = mask_ff;
    nxt_io_rdata_ff = io_rdata_ff;
    if (io_wr && io_addr == pgd_pkg::PGD_INDEX_PORT) begin
      nxt_idx_ff = io_wdata[3:0]; // RL1 RL2
    end
    if (io_wr && io_addr == pgd_pkg::PGD_DATA_PORT) begin
      case (idx_ff) // RL1 RL3
        pgd_pkg::PGD_IDX_FILL: nxt_fill_ff = io_wdata[3:0];
        pgd_pkg::PGD_IDX_FILL_EN: nxt_fill_en_ff = io_wdata[3:0];
        pgd_pkg::PGD_IDX_CMP: nxt_cmp_ff = io_wdata[3:0];
        pgd_pkg::PGD_IDX_OPROT: begin
          nxt_rot_ff = io_wdata[pgd_pkg::PGD_ROT_MSB:0];
          nxt_op_ff = pgd_pkg::pgd_op_e'(io_wdata[pgd_pkg::PGD_OP_MSB:pgd_pkg::PGD_OP_LSB]);
        end
        pgd_pkg::PGD_IDX_RDPL: nxt_rdpl_ff = io_wdata[1:0];
        pgd_pkg::PGD_IDX_MODE: begin
          nxt_wmode_ff = pgd_pkg::pgd_wmode_e'(io_wdata[pgd_pkg::PGD_WM_MSB:0]);
          nxt_rdcmp_ff = io_wdata[pgd_pkg::PGD_RDCMP_BIT];
          nxt_oe_ff = io_wdata[pgd_pkg::PGD_OE_BIT];
          nxt_shf_oe_ff = io_wdata[pgd_pkg::PGD_SHF_OE_BIT];
          nxt_shf256_ff = io_wdata[pgd_pkg::PGD_SHF256_BIT];
        end
        pgd_pkg::PGD_IDX_IGNORE: nxt_ignore_ff = io_wdata[3:0];
        pgd_pkg::PGD_IDX_MASK: nxt_mask_ff = io_wdata;
        default: nxt_mask_ff = mask_ff;
      endcase
    end
    if (io_rd && io_addr == pgd_pkg::PGD_INDEX_PORT) begin
      nxt_io_rdata_ff = {pgd_pkg::PGD_NIBBLE_ZERO, idx_ff}; // RL2
    end else if (io_rd && io_addr == pgd_pkg::PGD_DATA_PORT) begin
      nxt_io_rdata_ff = reg_view; // RL3
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      idx_ff <= '0;
      fill_ff <= '0;
      fill_en_ff <= '0;
      cmp_ff <= '0;
      rot_ff <= '0;
      op_ff <= pgd_pkg::PGD_OP_PASS;
      rdpl_ff <= '0;
      wmode_ff <= pgd_pkg::PGD_WM0;
      rdcmp_ff <= 1'b0;
      oe_ff <= 1'b0;
      shf_oe_ff <= 1'b0;
      shf256_ff <= 1'b0;
      ignore_ff <= '0;
      mask_ff <= '0;
      io_rdata_ff <= '0;
    end else begin
      idx_ff <= nxt_idx_ff;
      fill_ff <= nxt_fill_ff;
      fill_en_ff <= nxt_fill_en_ff;
      cmp_ff <= nxt_cmp_ff;
      rot_ff <= nxt_rot_ff;
      op_ff <= nxt_op_ff;
      rdpl_ff <= nxt_rdpl_ff;
      wmode_ff <= nxt_wmode_ff;
      rdcmp_ff <= nxt_rdcmp_ff;
      oe_ff <= nxt_oe_ff;
      shf_oe_ff <= nxt_shf_oe_ff;
      shf256_ff <= nxt_shf256_ff;
      ignore_ff <= nxt_ignore_ff;
      mask_ff <= nxt_mask_ff;
      io_rdata_ff <= nxt_io_rdata_ff;
    end
  end

  // odd/even: the address bit replaces the low plane-select bit
  assign rd_plane = oe_ff ? {rdpl_ff[1], cpu_a0} : rdpl_ff; // RL9 RL16

  always_comb begin
    logic [3:0] px;
    px = pgd_pkg::PGD_NIBBLE_ZERO;
    nxt_latch_ff = latch_ff;
    nxt_cpu_rdata_ff = cpu_rdata_ff;
    nxt_mem_wdata_ff = mem_wdata_ff;
    nxt_we_ff = pgd_pkg::PGD_NIBBLE_ZERO;
    if (cpu_rd) begin
      nxt_latch_ff = mem_rdata; // RL14
      if (rdcmp_ff) begin
        for (int b = 0; b < 8; b++) begin
          for (int p = 0; p < 4; p++) begin
            px[p] = mem_rdata[8*p + b];
          end
          nxt_cpu_rdata_ff[b] = ~|((px ^ cmp_ff) & ignore_ff); // RL6 RL15 RL20
        end
      end else begin
        nxt_cpu_rdata_ff = mem_rdata[8*rd_plane +: 8]; // RL9 RL15
      end
    end
    // registers are sampled in the access cycle, so a prior port write is already visible
    if (cpu_wr) begin
      nxt_mem_wdata_ff = lane_out; // RL21
      if (oe_ff) begin
        nxt_we_ff = cpu_a0 ? pgd_pkg::PGD_ODD_PLANES : pgd_pkg::PGD_EVEN_PLANES; // RL16
      end else begin
        nxt_we_ff = pgd_pkg::PGD_ALL_PLANES;
      end
    end
    if (shf256_ff) begin
      nxt_shift_ff = pgd_pkg::PGD_SHF_256; // RL18
    end else if (shf_oe_ff) begin
      nxt_shift_ff = pgd_pkg::PGD_SHF_ODD_EVEN; // RL17
    end else begin
      nxt_shift_ff = pgd_pkg::PGD_SHF_NORMAL;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latch_ff <= '0;
      cpu_rdata_ff <= '0;
      mem_wdata_ff <= '0;
      we_ff <= '0;
      shift_ff <= pgd_pkg::PGD_SHF_NORMAL;
    end else begin
      latch_ff <= nxt_latch_ff;
      cpu_rdata_ff <= nxt_cpu_rdata_ff;
      mem_wdata_ff <= nxt_mem_wdata_ff;
      we_ff <= nxt_we_ff;
      shift_ff <= nxt_shift_ff;
    end
  end

  assign io_rdata = io_rdata_ff;
  assign cpu_rdata = cpu_rdata_ff;
  assign mem_wdata = mem_wdata_ff;
  assign mem_plane_we = we_ff;
  assign shift_format = shift_ff;

  property p_idx_read;
    @(posedge sys_clk) disable iff (rst)
    io_rd && io_addr == pgd_pkg::PGD_INDEX_PORT |=> io_rdata[7:4] == 4'h0 && io_rdata[3:0] == $past(idx_ff);
  endproperty
  a_idx_read: assert property (p_idx_read) else $error("index readback wrong"); // RL2

  property p_fill_write;
    @(posedge sys_clk) disable iff (rst)
    io_wr && io_addr == pgd_pkg::PGD_DATA_PORT && idx_ff == pgd_pkg::PGD_IDX_FILL
      |=> fill_ff == $past(io_wdata[3:0]);
  endproperty
  a_fill_write: assert property (p_fill_write) else $error("data port write not stored"); // RL3

  property p_latch_load;
    @(posedge sys_clk) disable iff (rst)
    cpu_rd |=> latch_ff == $past(mem_rdata);
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("latches not loaded on read"); // RL14

  property p_mode1;
    @(posedge sys_clk) disable iff (rst)
    cpu_wr && wmode_ff == pgd_pkg::PGD_WM1 |=> mem_wdata == $past(latch_ff);
  endproperty
  a_mode1: assert property (p_mode1) else $error("mode 1 did not copy latches"); // RL11

  property p_mask_zero;
    @(posedge sys_clk) disable iff (rst)
    cpu_wr && wmode_ff != pgd_pkg::PGD_WM1
      |=> ((mem_wdata ^ $past(latch_ff)) & ~$past({4{mask_ff}})) == 32'h0000_0000;
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("masked pixels changed"); // RL19

  property p_odd_write;
    @(posedge sys_clk) disable iff (rst)
    cpu_wr && oe_ff |=> mem_plane_we == ($past(cpu_a0) ? 4'ha : 4'h5) ##1 mem_plane_we == 4'h0 || $past(cpu_wr);
  endproperty
  a_odd_write: assert property (p_odd_write) else $error("odd/even plane enables wrong"); // RL16

  property p_read0;
    @(posedge sys_clk) disable iff (rst)
    cpu_rd && !rdcmp_ff && !oe_ff |=> cpu_rdata == $past(mem_rdata[8*rdpl_ff +: 8]);
  endproperty
  a_read0: assert property (p_read0) else $error("read mode 0 plane wrong"); // RL9

  property p_cmp_ignore;
    @(posedge sys_clk) disable iff (rst)
    cpu_rd && rdcmp_ff && ignore_ff == 4'h0 |=> cpu_rdata == 8'hff;
  endproperty
  a_cmp_ignore: assert property (p_cmp_ignore) else $error("ignored planes compared"); // RL20

  property p_mode3;
    @(posedge sys_clk) disable iff (rst)
    cpu_wr && wmode_ff == pgd_pkg::PGD_WM3 && op_ff == pgd_pkg::PGD_OP_PASS
      |=> ((mem_wdata ^ {{8{$past(fill_ff[3])}}, {8{$past(fill_ff[2])}}, {8{$past(fill_ff[1])}},
      {8{$past(fill_ff[0])}}}) & $past({4{rot_wide[7:0] & mask_ff}})) == 32'h0000_0000;
  endproperty
  a_mode3: assert property (p_mode3) else $error("mode 3 fill wrong"); // RL13

  // the 256-colour format must win whatever the odd/even shift bit says
  property p_shift256;
    @(posedge sys_clk) disable iff (rst)
    shf256_ff |=> shift_format == pgd_pkg::PGD_SHF_256;
  endproperty
  a_shift256: assert property (p_shift256) else $error("256-colour shift format not selected"); // RL18

  property p_mode0_plain;
    @(posedge sys_clk) disable iff (rst)
    cpu_wr && wmode_ff == pgd_pkg::PGD_WM0 && fill_en_ff == 4'h0 && rot_ff == 3'h0
      && op_ff == pgd_pkg::PGD_OP_PASS && mask_ff == 8'hff |=> mem_wdata == {4{$past(cpu_wdata)}};
  endproperty
  a_mode0_plain: assert property (p_mode0_plain) else $error("unrotated mode 0 data wrong"); // RL7
endmodule : pgd_datapath
`default_nettype wire

/* File: pgd_pkg.sv */
// constants, encodings and field layout of the planar graphics datapath
// Overview of operation
// RL1 - write index port, then access data port
// RL2 - index holds four bits, upper bits read zero
// RL3 - data port reaches full selected register byte; only the mask register keeps all eight bits
// RL4 - fill colour bit replicated across plane byte
// RL5 - mode 0: enabled planes take fill colour
// RL6 - compare mode returns per-pixel colour match
// RL7 - write data rotated right; zero means none
// RL8 - logic op: pass, and, or, xor
// RL9 - read mode 0 plane field selects plane
// RL10 - mode 0: rotated data, op and mask
// RL11 - mode 1 writes latches, all else ignored
// RL12 - mode 2 replicates data bit n per plane
// RL13 - mode 3: fill colour, rotated data masks
// RL14 - every memory read loads four plane latches
// RL15 - compare enable bit picks read mode
// RL16 - odd/even steers even and odd addresses
// RL17 - odd/even shift format for display
// RL18 - 256-colour shift format overrides odd/even
// RL19 - mask zero keeps latched pixel in planes
// RL20 - ignore bit zero drops plane from compare
// RL21 - register write effective for next access
`default_nettype none
package pgd_pkg;
  localparam logic [15:0] PGD_INDEX_PORT = 16'h03ce;
  localparam logic [15:0] PGD_DATA_PORT = 16'h03cf;
  localparam logic [3:0] PGD_IDX_FILL = 4'h0;
  localparam logic [3:0] PGD_IDX_FILL_EN = 4'h1;
  localparam logic [3:0] PGD_IDX_CMP = 4'h2;
  localparam logic [3:0] PGD_IDX_OPROT = 4'h3;
  localparam logic [3:0] PGD_IDX_RDPL = 4'h4;
  localparam logic [3:0] PGD_IDX_MODE = 4'h5;
  localparam logic [3:0] PGD_IDX_IGNORE = 4'h7;
  localparam logic [3:0] PGD_IDX_MASK = 4'h8;
  localparam int PGD_ROT_MSB = 2;
  localparam int PGD_OP_MSB = 4;
  localparam int PGD_OP_LSB = 3;
  localparam int PGD_WM_MSB = 1;
  localparam int PGD_RDCMP_BIT = 3;
  localparam int PGD_OE_BIT = 4;
  localparam int PGD_SHF_OE_BIT = 5;
  localparam int PGD_SHF256_BIT = 6;
  localparam logic [3:0] PGD_ALL_PLANES = 4'hf;
  localparam logic [3:0] PGD_EVEN_PLANES = 4'h5;
  localparam logic [3:0] PGD_ODD_PLANES = 4'ha;
  localparam logic [3:0] PGD_NIBBLE_ZERO = 4'h0;
  localparam logic [7:0] PGD_BYTE_ZERO = 8'h00;
  typedef enum logic [1:0] {
    PGD_WM0 = 2'b00,
    PGD_WM1 = 2'b01,
    PGD_WM2 = 2'b10,
    PGD_WM3 = 2'b11
  } pgd_wmode_e;
  typedef enum logic [1:0] {
    PGD_OP_PASS = 2'b00,
    PGD_OP_AND = 2'b01,
    PGD_OP_OR = 2'b10,
    PGD_OP_XOR = 2'b11
  } pgd_op_e;
  typedef enum logic [1:0] {
    PGD_SHF_NORMAL = 2'b00,
    PGD_SHF_ODD_EVEN = 2'b01,
    PGD_SHF_256 = 2'b10
  } pgd_shift_e;
endpackage : pgd_pkg
`default_nettype wire

/* File: pgd_lane_if.sv */
// shared write-path controls fanned out to the four plane lanes
`default_nettype none
interface pgd_lane_if;
  logic [7:0] rot_data;
  logic [7:0] cpu_data;
  logic [7:0] bit_mask;
  logic [3:0] fill;
  logic [3:0] fill_en;
  pgd_pkg::pgd_wmode_e wmode;
  pgd_pkg::pgd_op_e op;
  modport driver (output rot_data, cpu_data, bit_mask, fill, fill_en, wmode, op);
  modport lane (input rot_data, cpu_data, bit_mask, fill, fill_en, wmode, op);
endinterface : pgd_lane_if
`default_nettype wire

/* File: pgd_plane_lane.sv */
// write data former for one memory plane
`default_nettype none
module pgd_plane_lane #(
  parameter int PLANE = 0
) (
  pgd_lane_if.lane lif,
  input wire logic [7:0] latch,
  output logic [7:0] result
);
  logic [7:0] src;
  logic [7:0] alu;
  logic [7:0] mask;

  always_comb begin
    src = lif.rot_data;
    mask = lif.bit_mask;
    case (lif.wmode)
      pgd_pkg::PGD_WM0: begin
        if (lif.fill_en[PLANE]) begin
          src = {8{lif.fill[PLANE]}}; // RL4 RL5
        end
      end
      pgd_pkg::PGD_WM2: src = {8{lif.cpu_data[PLANE]}}; // RL12
      pgd_pkg::PGD_WM3: begin
        src = {8{lif.fill[PLANE]}}; // RL13
        mask = lif.rot_data & lif.bit_mask; // RL13
      end
      default: src = lif.rot_data;
    endcase
    case (lif.op)
      pgd_pkg::PGD_OP_AND: alu = src & latch; // RL8
      pgd_pkg::PGD_OP_OR: alu = src | latch;
      pgd_pkg::PGD_OP_XOR: alu = src ^ latch;
      default: alu = src;
    endcase
    // mode 1 bypasses op, rotation and mask entirely
    if (lif.wmode == pgd_pkg::PGD_WM1) begin
      result = latch; // RL11
    end else begin
      result = (alu & mask) | (latch & ~mask); // RL10 RL19
    end
  end
endmodule : pgd_plane_lane
`default_nettype wire

/* File: pgd_vmem_model.sv */
// video memory stand-in: one word of four plane bytes
`default_nettype none
module pgd_vmem_model (
  input wire logic sys_clk,
  input wire logic cpu_rd,
  input wire logic load_en,
  input wire logic [31:0] load_val,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] mem_plane_we,
  output logic [31:0] mem_rdata,
  output logic [31:0] word_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] nxt_word;
  always_comb begin
    nxt_word = word_ff;
    for (int n = 0; n < 4; n++) begin
      if (mem_plane_we[n]) begin
        nxt_word[8*n +: 8] = mem_wdata[8*n +: 8];
      end
    end
    if (load_en) begin
      nxt_word = load_val;
    end
  end
  always_ff @(posedge sys_clk) begin
    word_ff <= nxt_word;
  end
  // inverted outside the read cycle so a mistimed sample cannot match by luck
  assign mem_rdata = cpu_rd ? word_ff : ~word_ff;
endmodule : pgd_vmem_model
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the planar graphics datapath
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] W = 32'hc35a_e721;
  localparam logic [7:0] RMASK [0:8] = '{8'h0f, 8'h0f, 8'h0f, 8'h1f, 8'h03, 8'h7b, 8'h00, 8'h0f, 8'hff};
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'h0;
  logic io_rd = 1'h0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic cpu_wr = 1'h0;
  logic cpu_rd = 1'h0;
  logic cpu_a0 = 1'h0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata;
  logic [31:0] mem_rdata;
  logic [31:0] mem_wdata;
  logic [31:0] word;
  logic [3:0] mem_plane_we;
  logic [1:0] shift_format;
  logic load_en = 1'h0;
  logic [31:0] load_val = 32'h0000_0000;
  logic [7:0] regs [0:15];
  logic [31:0] latch_v;
  int error_cnt = 0;
  int n_tests = 0;
  always #2.5 sys_clk = ~sys_clk;
  pgd_datapath dut_u (.sys_clk, .rst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .cpu_wr, .cpu_rd,
    .cpu_a0, .cpu_wdata, .cpu_rdata, .mem_rdata, .mem_wdata, .mem_plane_we, .shift_format);
  pgd_vmem_model vmem_u (.sys_clk, .cpu_rd, .load_en, .load_val, .mem_wdata, .mem_plane_we, .mem_rdata,
    .word_ff(word));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic io_cycle(input logic [15:0] a, input logic wr, input logic [7:0] d);
    @(negedge sys_clk);
    io_addr = a;
    io_wr = wr;
    io_rd = !wr;
    io_wdata = d;
    @(negedge sys_clk);
    io_wr = 1'h0;
    io_rd = 1'h0;
  endtask : io_cycle
  task automatic reg_wr(input logic [3:0] idx, input logic [7:0] d);
    io_cycle(pgd_pkg::PGD_INDEX_PORT, 1'h1, {4'h0, idx});
    io_cycle(pgd_pkg::PGD_DATA_PORT, 1'h1, d);
    regs[idx] = d;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] idx, input logic [7:0] exp);
    io_cycle(pgd_pkg::PGD_INDEX_PORT, 1'h1, {4'h0, idx});
    io_cycle(pgd_pkg::PGD_DATA_PORT, 1'h0, 8'h00);
    chk("io_rdata", exp, io_rdata);
  endtask : reg_rd
  // the word is preloaded first, so the read also fixes the latch contents
  task automatic cpu_read(input logic a0);
    @(negedge sys_clk);
    load_en = 1'h1;
    load_val = W;
    @(negedge sys_clk);
    load_en = 1'h0;
    cpu_rd = 1'h1;
    cpu_a0 = a0;
    @(negedge sys_clk);
    cpu_rd = 1'h0;
    latch_v = W;
  endtask : cpu_read
  task automatic cpu_write(input logic a0, input logic [7:0] d);
    @(negedge sys_clk);
    cpu_wr = 1'h1;
    cpu_a0 = a0;
    cpu_wdata = d;
    @(negedge sys_clk);
    cpu_wr = 1'h0;
  endtask : cpu_write
  function automatic logic [31:0] exp_write(input logic [7:0] d);
    logic [7:0] rot;
    logic [7:0] m;
    logic [7:0] v;
    logic [7:0] l;
    logic [31:0] r;
    rot = 8'({d, d} >> regs[3][2:0]);
    m = (regs[5][1:0] == 2'h3) ? (rot & regs[8]) : regs[8];
    for (int n = 0; n < 4; n++) begin
      l = latch_v[8*n +: 8];
      case (regs[5][1:0])
        2'h0: v = regs[1][n] ? {8{regs[0][n]}} : rot;
        2'h2: v = {8{d[n]}};
        default: v = {8{regs[0][n]}};
      endcase
      case (regs[3][4:3])
        2'h1: v = v & l;
        2'h2: v = v | l;
        2'h3: v = v ^ l;
        default: v = v;
      endcase
      r[8*n +: 8] = (regs[5][1:0] == 2'h1) ? l : ((v & m) | (l & ~m));
    end
    return r;
  endfunction : exp_write
  function automatic logic [7:0] exp_cmp();
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = 1'h1;
      for (int n = 0; n < 4; n++) begin
        if (regs[7][n] && (W[8*n+i] != regs[2][n])) begin
          r[i] = 1'h0;
        end
      end
    end
    return r;
  endfunction : exp_cmp
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 16; i++) begin
      regs[i] = 8'h00;
    end
    repeat (10) @(negedge sys_clk);
    rst = 1'h0;
    chk("cpu_rdata", 32'h0000_0000, cpu_rdata);
    chk("shift_format", 32'h0000_0000, shift_format);
    for (int i = 0; i < 9; i++) begin
      reg_wr(4'(i), 8'hff);
      reg_rd(4'(i), RMASK[i]);
    end
    chk("shift_format", 32'h0000_0002, shift_format);
    io_cycle(pgd_pkg::PGD_INDEX_PORT, 1'h1, 8'hfa);
    io_cycle(16'h03cd, 1'h1, 8'h03);
    io_cycle(pgd_pkg::PGD_INDEX_PORT, 1'h0, 8'h00);
    chk("index", 32'h0000_000a, io_rdata);
    reg_wr(4'h5, 8'h20);
    // the shift format follows the mode register one edge later
    @(negedge sys_clk);
    chk("shift_format", 32'h0000_0001, shift_format);
    reg_wr(4'h5, 8'h00);
    for (int p = 0; p < 4; p++) begin
      reg_wr(4'h4, 8'(p));
      cpu_read(1'h0);
      chk("plane read", W[8*p +: 8], cpu_rdata);
    end
    reg_wr(4'h5, 8'h10);
    reg_wr(4'h4, 8'h02);
    cpu_read(1'h1);
    chk("odd read", W[31:24], cpu_rdata);
    cpu_read(1'h0);
    chk("even read", W[23:16], cpu_rdata);
    reg_wr(4'h1, 8'h00);
    reg_wr(4'h3, 8'h00);
    cpu_write(1'h1, 8'h96);
    chk("plane_we", 32'h0000_000a, mem_plane_we);
    @(negedge sys_clk);
    chk("plane_we", 32'h0000_0000, mem_plane_we);
    chk("memory word", {8'h96, W[23:16], 8'h96, W[7:0]}, word);
    reg_wr(4'h5, 8'h08);
    for (int k = 0; k < 3; k++) begin
      reg_wr(4'h2, 8'(5 * k + 5));
      reg_wr(4'h7, 8'(15 - 7 * k));
      cpu_read(1'h0);
      chk("compare", exp_cmp(), cpu_rdata);
    end
    reg_wr(4'h7, 8'h00);
    cpu_read(1'h0);
    chk("compare", exp_cmp(), cpu_rdata);
    reg_wr(4'h0, 8'h05);
    reg_wr(4'h1, 8'h03);
    reg_wr(4'h8, 8'h3c);
    cpu_read(1'h0);
    for (int m = 0; m < 4; m++) begin
      for (int o = 0; o < 4; o++) begin
        reg_wr(4'h5, 8'(m));
        reg_wr(4'h3, {3'h0, 2'(o), 3'(m + o)});
        cpu_write(1'h0, 8'hb4);
        chk("mem_wdata", exp_write(8'hb4), mem_wdata);
        chk("plane_we", 32'h0000_000f, mem_plane_we);
      end
    end
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
